//--- shared/nvm_port_defs.svh
// Constants of the parallel programming port
`ifndef NVM_PORT_DEFS_SVH
`define NVM_PORT_DEFS_SVH
`define CLK_PERIOD_NS 8
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EE 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EE 8'h03
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3
`define BS_LOW 2'h0
`define BS_HIGH 2'h1
`define BS_EXT 2'h2
`define BS_TOP 2'h3
`define T_WRITE_NS 3700000
`define T_ERASE_NS 7500000
`define T_PULSE_NS 150
`define T_SETUP_NS 67
`define T_WLRL_NS 1000
`define T_OLDV_NS 250
`define FUSE_LO_RST 8'hff
`define FUSE_HI_RST 8'hff
`define FUSE_EXT_RST 8'hff
`define LOCK_RST 8'hff
`define LOCK_MAIN_MSB 1
`define LOCK_BOOT_LSB 2
`define LOCK_BOOT_MSB 5
`define REG_STEP 4'h0
`define REG_STATUS 4'h4
`define REG_RDATA 4'h8
`define STEP_BYTE_LSB 0
`define STEP_ACT_LSB 8
`define STEP_BS_LSB 10
`define STEP_KIND_LSB 12
`define KIND_LOAD 2'h0
`define KIND_LATCH 2'h1
`define KIND_WRITE 2'h2
`define KIND_READ 2'h3
`endif

//--- shared/nvm_port_pkg.sv
// Types shared by both ends of the parallel programming port
package nvm_port_pkg;
	typedef enum logic [2:0] {OP_NONE, OP_FLASH, OP_EE, OP_FUSE_LO, OP_FUSE_HI, OP_FUSE_EXT,
		OP_LOCK, OP_ERASE} op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_WAIT} dev_state_t;
	typedef enum logic [2:0] {P_IDLE, P_SETUP, P_PULSE, P_WAIT_LOW, P_WAIT_HIGH,
		P_HOLD} prg_state_t;
endpackage

//--- shared/nvm_port_if.sv
// Pins between the programmer and the device
`timescale 1ns/1ns
interface nvm_port_if;
	logic       load_strobe;
	logic       action_select_hi;
	logic       action_select_lo;
	logic       byte_select_1;
	logic       byte_select_2;
	logic       page_latch_strobe;
	logic       write_strobe_n;
	logic       output_enable_n;
	logic       ready_busy;
	logic [7:0] prog_data_out;
	logic       prog_data_oe_n;
	logic [7:0] dev_data_out;
	logic       dev_data_oe_n;
	logic [7:0] data_bus;
	// Wire level of the shared data bus, pulled high when nobody drives
	assign data_bus = !dev_data_oe_n ? dev_data_out :
		(!prog_data_oe_n ? prog_data_out : 8'hff);
	modport dev (input load_strobe, action_select_hi, action_select_lo, byte_select_1,
		byte_select_2, page_latch_strobe, write_strobe_n, output_enable_n, data_bus,
		output ready_busy, dev_data_out, dev_data_oe_n);
	modport prog (output load_strobe, action_select_hi, action_select_lo, byte_select_1,
		byte_select_2, page_latch_strobe, write_strobe_n, output_enable_n, prog_data_out,
		prog_data_oe_n, input ready_busy, data_bus);
endinterface

//--- logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// A bit changes once stages two and three agree
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			level  <= RESET_VAL;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level  <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level);
		end
	end
endmodule

//--- logic/nvm_device_end.sv
// Device end: command, address and data loading, page buffers, self-timed writes, reads
`timescale 1ns/1ns
`include "nvm_port_defs.svh"
//
// Functional notes
// - Data load with select high: high data byte
// - Page latch with select high buffers word
// - Low bits pick word, upper bits pick page
// - Address load, pair 01: address bits 15..8
// - Address load, pair 10: address bits 23..16
// - Write strobe, flash command: page write, busy
// - No-operation command clears write controls
// - EEPROM: address, data, latch per byte
// - Write strobe starts EEPROM page, busy
// - Flash read: select picks low/high byte
// - EEPROM read drives addressed byte
// - Fuse command, pair 00: low fuse
// - Pair 01 at strobe: high fuse
// - Pair 10 at strobe: extended fuse
// - Lock write: zero bits program lock bits
// - Lock mode 3 blocks boot lock programming
// - Only chip erase unprograms lock bits
// - Status read: pair picks fuse/lock byte
// - Signature read by low address 0..2
// - Action select decodes each load strobe while not busy
// - Flash write starts with its command
// - Ready low during self-timed operation
// - Data bus driven only while enable low
module nvm_device_end #(
	parameter int         FLASH_WORDS  = 16384,
	parameter int         PAGE_WORDS   = 128,
	parameter int         EE_BYTES     = 1024,
	parameter int         EE_PAGE      = 8,
	parameter int         WRITE_CYCLES = (`T_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int         ERASE_CYCLES = (`T_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter logic [7:0] SIG_0        = 8'h5a, // arbitrary value
	parameter logic [7:0] SIG_1        = 8'h3c, // arbitrary value
	parameter logic [7:0] SIG_2        = 8'h0f, // arbitrary value
	parameter logic [7:0] CAL_BYTE     = 8'h80
)
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	nvm_port_if.dev         port,
	output logic            busy,
	output logic      [7:0] active_cmd
);
	import nvm_port_pkg::*;

	localparam int FA  = $clog2(FLASH_WORDS);
	localparam int PW  = $clog2(PAGE_WORDS);
	localparam int EA  = $clog2(EE_BYTES);
	localparam int EPW = $clog2(EE_PAGE);

	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic [15:0] pins;
	logic [15:0] pins_prev_reg;
	logic [7:0]  din;
	logic [1:0]  act;
	logic [1:0]  bs_pair;
	logic        bs1;
	logic        load_rise;
	logic        latch_rise;
	logic        wr_fall;

	pin_sync #(.WIDTH(16), .RESET_VAL(16'hff63)) u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   ({port.data_bus, port.load_strobe, port.action_select_hi,
			port.action_select_lo, port.byte_select_1, port.byte_select_2,
			port.page_latch_strobe, port.write_strobe_n, port.output_enable_n}),
		.level    (pins)
	);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pins_prev_reg <= 16'hff63;
		else
			pins_prev_reg <= pins;
	end

	assign din        = pins[15:8];
	assign act        = pins[6:5];
	assign bs1        = pins[4];
	assign bs_pair    = {pins[3], pins[4]};
	assign load_rise  = pins[7] & ~pins_prev_reg[7];
	assign latch_rise = pins[2] & ~pins_prev_reg[2];
	assign wr_fall    = ~pins[1] & pins_prev_reg[1];

	// ****************************************
	// Command, address and data loading
	// ****************************************
	dev_state_t  state_reg;
	logic [7:0]  addr_lo_reg;
	logic [7:0]  addr_hi_reg;
	logic [7:0]  addr_ext_reg;
	logic [7:0]  data_lo_reg;
	logic [7:0]  data_hi_reg;
	logic [23:0] full_addr;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			active_cmd   <= `CMD_NOP;
			addr_lo_reg  <= 8'h00;
			addr_hi_reg  <= 8'h00;
			addr_ext_reg <= 8'h00;
			data_lo_reg  <= 8'hff;
			data_hi_reg  <= 8'hff;
		end
		else if (load_rise && state_reg == ST_IDLE)
		begin
			unique case (act)
				`ACT_ADDR:
					case (bs_pair)
						`BS_LOW:
							addr_lo_reg <= din;
						`BS_HIGH:
							addr_hi_reg <= din;
						`BS_EXT:
							addr_ext_reg <= din;
						default:
							;
					endcase
				`ACT_DATA:
					if (bs1)
						data_hi_reg <= din;
					else
						data_lo_reg <= din;
				`ACT_CMD:
					active_cmd <= din;
				`ACT_IDLE:
					;
			endcase
		end
	end

	assign full_addr = {addr_ext_reg, addr_hi_reg, addr_lo_reg};

	// ****************************************
	// Page buffers
	// ****************************************
	logic [15:0] fbuf [PAGE_WORDS];
	logic [7:0]  ebuf [EE_PAGE];

	always_ff @(posedge core_clk)
	begin
		if (latch_rise && state_reg == ST_IDLE)
		begin
			if (active_cmd == `CMD_WR_FLASH && bs1)
				fbuf[addr_lo_reg[PW-1:0]] <= {data_hi_reg, data_lo_reg};
			else if (active_cmd == `CMD_WR_EE)
				ebuf[addr_lo_reg[EPW-1:0]] <= data_lo_reg;
		end
	end

	// ****************************************
	// Write start decode
	// ****************************************
	op_t start_op;

	always_comb
	begin
		start_op = OP_NONE;
		if (wr_fall && state_reg == ST_IDLE)
		begin
			case (active_cmd)
				`CMD_WR_FLASH:
					if (bs_pair == `BS_LOW)
						start_op = OP_FLASH;
				`CMD_WR_EE:
					if (bs_pair == `BS_LOW)
						start_op = OP_EE;
				`CMD_WR_FUSE:
					case (bs_pair)
						`BS_LOW:
							start_op = OP_FUSE_LO;
						`BS_HIGH:
							start_op = OP_FUSE_HI;
						`BS_EXT:
							start_op = OP_FUSE_EXT;
						default:
							start_op = OP_NONE;
					endcase
				`CMD_WR_LOCK:
					start_op = OP_LOCK;
				`CMD_ERASE:
					start_op = OP_ERASE;
				default:
					start_op = OP_NONE;
			endcase
		end
	end

	// ****************************************
	// Self-timed operation sequencer
	// ****************************************
	op_t         op_reg;
	logic [FA-1:0] idx_reg;
	logic [FA-1:0] last_idx;
	logic [FA-1:0] waddr_reg;
	logic [19:0] timer_reg;
	logic        ready_reg;

	always_comb
	begin
		unique case (op_reg)
			OP_FLASH:
				last_idx = FA'(PAGE_WORDS - 1);
			OP_EE:
				last_idx = FA'(EE_PAGE - 1);
			OP_ERASE:
				last_idx = FA'(FLASH_WORDS - 1);
			default:
				last_idx = '0;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= ST_IDLE;
			op_reg    <= OP_NONE;
			idx_reg   <= '0;
			waddr_reg <= '0;
			timer_reg <= 20'h0_0000;
			ready_reg <= 1'b1;
			busy      <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (start_op != OP_NONE)
					begin
						state_reg <= ST_COPY;
						op_reg    <= start_op;
						idx_reg   <= '0;
						waddr_reg <= full_addr[FA-1:0];
						timer_reg <= (start_op == OP_ERASE) ? 20'(ERASE_CYCLES) :
							20'(WRITE_CYCLES);
						ready_reg <= 1'b0;
						busy      <= 1'b1;
					end
				ST_COPY:
				begin
					timer_reg <= timer_reg - 20'h0_0001;
					if (idx_reg == last_idx)
						state_reg <= ST_WAIT;
					else
						idx_reg <= idx_reg + 1'b1;
				end
				ST_WAIT:
					if (timer_reg <= 20'h0_0001)
					begin
						state_reg <= ST_IDLE;
						ready_reg <= 1'b1;
						busy      <= 1'b0;
					end
					else
						timer_reg <= timer_reg - 20'h0_0001;
			endcase
		end
	end

	assign port.ready_busy = ready_reg;

	// ****************************************
	// Memory arrays
	// ****************************************
	logic [15:0] flash_mem [FLASH_WORDS];
	logic [7:0]  ee_mem [EE_BYTES];

	always_ff @(posedge core_clk)
	begin
		if (state_reg == ST_COPY)
		begin
			case (op_reg)
				OP_FLASH:
					flash_mem[{waddr_reg[FA-1:PW], idx_reg[PW-1:0]}] <=
						fbuf[idx_reg[PW-1:0]];
				OP_EE:
					ee_mem[{waddr_reg[EA-1:EPW], idx_reg[EPW-1:0]}] <=
						ebuf[idx_reg[EPW-1:0]];
				OP_ERASE:
				begin
					flash_mem[idx_reg] <= 16'hffff;
					if (idx_reg < FA'(EE_BYTES))
						ee_mem[idx_reg[EA-1:0]] <= 8'hff;
				end
				default:
					;
			endcase
		end
	end

	// ****************************************
	// Fuse and lock bytes
	// ****************************************
	logic [7:0] fuse_lo_reg;
	logic [7:0] fuse_hi_reg;
	logic [7:0] fuse_ext_reg;
	logic [7:0] lock_reg;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fuse_lo_reg  <= `FUSE_LO_RST;
			fuse_hi_reg  <= `FUSE_HI_RST;
			fuse_ext_reg <= `FUSE_EXT_RST;
			lock_reg     <= `LOCK_RST;
		end
		else if (state_reg == ST_COPY)
		begin
			case (op_reg)
				OP_FUSE_LO:
					fuse_lo_reg <= data_lo_reg;
				OP_FUSE_HI:
					fuse_hi_reg <= data_lo_reg;
				OP_FUSE_EXT:
					fuse_ext_reg <= data_lo_reg;
				OP_LOCK:
				begin
					lock_reg[`LOCK_MAIN_MSB:0] <= lock_reg[`LOCK_MAIN_MSB:0] &
						data_lo_reg[`LOCK_MAIN_MSB:0];
					if (lock_reg[`LOCK_MAIN_MSB:0] != 2'h0)
						lock_reg[`LOCK_BOOT_MSB:`LOCK_BOOT_LSB] <=
							lock_reg[`LOCK_BOOT_MSB:`LOCK_BOOT_LSB] &
							data_lo_reg[`LOCK_BOOT_MSB:`LOCK_BOOT_LSB];
				end
				OP_ERASE:
					if (idx_reg == last_idx)
						lock_reg <= `LOCK_RST;
				default:
					;
			endcase
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0]  rd_byte;
	logic [15:0] rd_word;
	logic [7:0]  data_out_reg;
	logic        data_oe_n_reg;

	assign rd_word = flash_mem[full_addr[FA-1:0]];

	always_comb
	begin
		rd_byte = 8'hff;
		case (active_cmd)
			`CMD_RD_FLASH:
				rd_byte = bs1 ? rd_word[15:8] : rd_word[7:0];
			`CMD_RD_EE:
				rd_byte = ee_mem[full_addr[EA-1:0]];
			`CMD_RD_FUSE:
				unique case (bs_pair)
					`BS_LOW:
						rd_byte = fuse_lo_reg;
					`BS_TOP:
						rd_byte = fuse_hi_reg;
					`BS_EXT:
						rd_byte = fuse_ext_reg;
					`BS_HIGH:
						rd_byte = lock_reg;
				endcase
			`CMD_RD_SIG:
				if (bs1)
					rd_byte = CAL_BYTE;
				else if (addr_lo_reg == 8'h00)
					rd_byte = SIG_0;
				else if (addr_lo_reg == 8'h01)
					rd_byte = SIG_1;
				else if (addr_lo_reg == 8'h02)
					rd_byte = SIG_2;
			default:
				rd_byte = 8'hff;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_out_reg  <= 8'hff;
			data_oe_n_reg <= 1'b1;
		end
		else
		begin
			data_out_reg  <= rd_byte;
			data_oe_n_reg <= pins[0];
		end
	end

	assign port.dev_data_out  = data_out_reg;
	assign port.dev_data_oe_n = data_oe_n_reg;
endmodule

//--- logic/nvm_programmer_end.sv
// Programmer end: runs one pin step per software write
`timescale 1ns/1ns
`include "nvm_port_defs.svh"
module nvm_programmer_end (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	nvm_port_if.prog         port,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             step_busy
);
	import nvm_port_pkg::*;

	localparam int SETUP_CYC = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int PULSE_CYC = (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int WLRL_CYC  = `T_WLRL_NS / `CLK_PERIOD_NS;
	localparam int OLDV_CYC  = `T_OLDV_NS / `CLK_PERIOD_NS;

	// ****************************************
	// Synchronised device pins
	// ****************************************
	logic [8:0] dev_pins;

	pin_sync #(.WIDTH(9), .RESET_VAL(9'h1ff)) u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   ({port.data_bus, port.ready_busy}),
		.level    (dev_pins)
	);

	// ****************************************
	// Step sequencer
	// ****************************************
	prg_state_t  state_reg;
	logic [15:0] step_reg;
	logic [7:0]  cnt_reg;
	logic [7:0]  rd_byte_reg;
	logic [1:0]  kind;
	logic        take;

	assign kind = step_reg[`STEP_KIND_LSB+1:`STEP_KIND_LSB];
	assign take = reg_wr && reg_addr == `REG_STEP && state_reg == P_IDLE;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg                 <= P_IDLE;
			step_reg                  <= 16'h0000;
			cnt_reg                   <= 8'h00;
			rd_byte_reg               <= 8'h00;
			step_busy                 <= 1'b0;
			port.load_strobe          <= 1'b0;
			port.page_latch_strobe    <= 1'b0;
			port.write_strobe_n       <= 1'b1;
			port.output_enable_n      <= 1'b1;
			port.action_select_hi     <= 1'b1;
			port.action_select_lo     <= 1'b1;
			port.byte_select_1        <= 1'b0;
			port.byte_select_2        <= 1'b0;
			port.prog_data_out        <= 8'h00;
			port.prog_data_oe_n       <= 1'b1;
		end
		else
		begin
			unique case (state_reg)
				P_IDLE:
					if (take)
					begin
						state_reg <= P_SETUP;
						step_reg  <= reg_wdata;
						step_busy <= 1'b1;
						cnt_reg   <= 8'(SETUP_CYC);
						{port.action_select_hi, port.action_select_lo} <=
							reg_wdata[`STEP_ACT_LSB+1:`STEP_ACT_LSB];
						{port.byte_select_2, port.byte_select_1} <=
							reg_wdata[`STEP_BS_LSB+1:`STEP_BS_LSB];
						port.prog_data_out  <= reg_wdata[`STEP_BYTE_LSB+7:`STEP_BYTE_LSB];
						port.prog_data_oe_n <= reg_wdata[`STEP_KIND_LSB+1:`STEP_KIND_LSB]
							!= `KIND_LOAD;
					end
				P_SETUP:
					if (cnt_reg <= 8'h01)
					begin
						state_reg <= P_PULSE;
						cnt_reg   <= (kind == `KIND_READ) ? 8'(OLDV_CYC) : 8'(PULSE_CYC);
						unique case (kind)
							`KIND_LOAD:
								port.load_strobe <= 1'b1;
							`KIND_LATCH:
								port.page_latch_strobe <= 1'b1;
							`KIND_WRITE:
								port.write_strobe_n <= 1'b0;
							`KIND_READ:
								port.output_enable_n <= 1'b0;
						endcase
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				P_PULSE:
					if (cnt_reg <= 8'h01)
					begin
						port.load_strobe       <= 1'b0;
						port.page_latch_strobe <= 1'b0;
						port.write_strobe_n    <= 1'b1;
						port.output_enable_n   <= 1'b1;
						if (kind == `KIND_READ)
							rd_byte_reg <= dev_pins[8:1];
						state_reg <= (kind == `KIND_WRITE) ? P_WAIT_LOW : P_HOLD;
						cnt_reg   <= (kind == `KIND_WRITE) ? 8'(WLRL_CYC) :
							((kind == `KIND_READ) ? 8'(OLDV_CYC) : 8'(SETUP_CYC));
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
				P_WAIT_LOW:
					if (cnt_reg <= 8'h01)
						state_reg <= P_WAIT_HIGH;
					else
						cnt_reg <= cnt_reg - 8'h01;
				P_WAIT_HIGH:
					if (dev_pins[0])
					begin
						state_reg <= P_HOLD;
						cnt_reg   <= 8'(SETUP_CYC);
					end
				P_HOLD:
					if (cnt_reg <= 8'h01)
					begin
						state_reg           <= P_IDLE;
						step_busy           <= 1'b0;
						port.prog_data_oe_n <= 1'b1;
					end
					else
						cnt_reg <= cnt_reg - 8'h01;
			endcase
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`REG_STEP:
					reg_rdata <= step_reg;
				`REG_STATUS:
					reg_rdata <= {14'h0000, dev_pins[0], step_busy};
				`REG_RDATA:
					reg_rdata <= {8'h00, rd_byte_reg};
				default:
					reg_rdata <= 16'h0000;
			endcase
		end
		else
			reg_rdata <= 16'h0000;
	end
endmodule

//--- verification/nvm_port_properties.sv
// Pin-level checks between the programmer and device ends
`timescale 1ns/1ns
module nvm_port_checker #(
	parameter int WRITE_CYCLES = 462500,
	parameter int ERASE_CYCLES = 937500
)
(
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       load_strobe,
	input wire logic       action_select_hi,
	input wire logic       action_select_lo,
	input wire logic       byte_select_1,
	input wire logic       byte_select_2,
	input wire logic       page_latch_strobe,
	input wire logic       write_strobe_n,
	input wire logic       output_enable_n,
	input wire logic       ready_busy,
	input wire logic       prog_data_oe_n,
	input wire logic       dev_data_oe_n,
	input wire logic [7:0] data_bus
);
	// ****
	// Command tracking and busy length
	// ****
	localparam int BUSY_MIN = WRITE_CYCLES - 12;
	localparam int BUSY_MAX = WRITE_CYCLES + 2;
	logic [7:0]  cmd_reg;
	logic        load_reg;
	logic [19:0] busy_reg;
	logic [1:0]  pair;
	assign pair = {byte_select_2, byte_select_1};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			load_reg <= 1'b0;
		else
			load_reg <= load_strobe;
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			cmd_reg <= 8'h00;
		else if (load_strobe && !load_reg && action_select_hi && !action_select_lo)
			cmd_reg <= data_bus;
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_reg <= 20'h0_0000;
		else if (ready_busy)
			busy_reg <= 20'h0_0000;
		else
			busy_reg <= busy_reg + 20'h0_0001;
	end
	load_width_a: assert property ($rose(load_strobe) |-> load_strobe [*8])
		else $error("load strobe pulse too short");
	load_stable_a: assert property (load_strobe && load_reg |->
		$stable({action_select_hi, action_select_lo, pair, data_bus}))
		else $error("load inputs moved during strobe");
	latch_select_a: assert property (page_latch_strobe && cmd_reg == 8'h10
		|-> byte_select_1) else $error("flash latch without high select");
	write_busy_a: assert property (
		$fell(write_strobe_n) && ready_busy && pair == 2'b00 &&
		cmd_reg inside {8'h10, 8'h11, 8'h20, 8'h80} |-> ##[1:10] !ready_busy)
		else $error("write did not go busy");
	fuse_busy_a: assert property (
		$fell(write_strobe_n) && ready_busy && cmd_reg == 8'h40 && pair != 2'b11
		|-> ##[1:10] !ready_busy) else $error("fuse write did not go busy");
	nop_idle_a: assert property ($fell(write_strobe_n) && cmd_reg == 8'h00
		|-> ready_busy [*8]) else $error("write after no-op went busy");
	busy_len_a: assert property ($rose(ready_busy) && cmd_reg != 8'h80
		|-> busy_reg >= BUSY_MIN && busy_reg <= BUSY_MAX) else $error("busy time out of range");
	erase_len_a: assert property ($rose(ready_busy) && cmd_reg == 8'h80
		|-> busy_reg >= ERASE_CYCLES - 12 && busy_reg <= ERASE_CYCLES + 2)
		else $error("erase time out of range");
	drive_on_a: assert property ($fell(output_enable_n) |-> ##[1:8] !dev_data_oe_n)
		else $error("device did not drive data");
	drive_off_a: assert property ($rose(output_enable_n) |-> ##[1:8] dev_data_oe_n)
		else $error("device did not release data");
	no_fight_a: assert property (!(!dev_data_oe_n && !prog_data_oe_n))
		else $error("both ends drive data");
	cover property ($fell(ready_busy));
	cover property ($fell(output_enable_n) && byte_select_1);
	cover property (page_latch_strobe && cmd_reg == 8'h11);
endmodule

//--- verification/parallel_nvm_programming_port_bench.sv
// Bench driving the programmer end against the device end
`timescale 1ns/1ns
`include "nvm_port_defs.svh"
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
		end \
	end
module parallel_nvm_programming_port_bench;
	// ****
	// Harness
	// ****
	localparam int         WR_CYC = 200;
	localparam logic [7:0] SIG [3] = '{8'h6b, 8'h2d, 8'hc4}; // arbitrary values
	localparam logic [7:0] FUSE [3] = '{8'he2, 8'hd9, 8'hf3};
	localparam logic [1:0] WPAIR [3] = '{`BS_LOW, `BS_HIGH, `BS_EXT};
	localparam logic [1:0] RPAIR [3] = '{`BS_LOW, `BS_TOP, `BS_EXT};
	logic        core_clk;
	logic        arst_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [7:0]  active_cmd;
	logic [15:0] rdv;
	int          mismatches;
	int          total_checks;
	int          busy_cycles = 0;
	int          b0;
	logic        dev_busy;
	nvm_port_if link ();
	nvm_programmer_end nvm_programmer_end_i (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.port      (link.prog),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.step_busy ()
	);
	nvm_device_end #(
		.WRITE_CYCLES (WR_CYC),
		.ERASE_CYCLES (20000),
		.SIG_0        (SIG[0]),
		.SIG_1        (SIG[1]),
		.SIG_2        (SIG[2]),
		.CAL_BYTE     (8'h6e)
	) nvm_device_end_i (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.port       (link.dev),
		.busy       (dev_busy),
		.active_cmd (active_cmd)
	);
	nvm_port_checker #(
		.WRITE_CYCLES (WR_CYC),
		.ERASE_CYCLES (20000)
	) nvm_port_checker_i (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.load_strobe       (link.load_strobe),
		.action_select_hi  (link.action_select_hi),
		.action_select_lo  (link.action_select_lo),
		.byte_select_1     (link.byte_select_1),
		.byte_select_2     (link.byte_select_2),
		.page_latch_strobe (link.page_latch_strobe),
		.write_strobe_n    (link.write_strobe_n),
		.output_enable_n   (link.output_enable_n),
		.ready_busy        (link.ready_busy),
		.prog_data_oe_n    (link.prog_data_oe_n),
		.dev_data_oe_n     (link.dev_data_oe_n),
		.data_bus          (link.data_bus)
	);
	initial core_clk = 1'b0;
	always #(`CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	always @(posedge core_clk)
		busy_cycles <= busy_cycles + int'(dev_busy);
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic step(input logic [1:0] kind, input logic [1:0] act, input logic [1:0] bs,
		input logic [7:0] b);
		logic [15:0] s;
		int          n;
		reg_write(`REG_STEP, {2'b00, kind, bs, act, b});
		s = 16'h0001;
		n = 0;
		while (s[0] !== 1'b0 && n < 15000)
		begin
			reg_read(`REG_STATUS, s);
			n++;
		end
		`CHK(s[0], 1'b0)
	endtask
	task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] b);
		step(`KIND_LOAD, act, bs, b);
	endtask
	task automatic rd_chk(input logic [1:0] bs, input logic [7:0] exp);
		step(`KIND_READ, `ACT_IDLE, bs, 8'h00);
		reg_read(`REG_RDATA, rdv);
		`CHK(rdv[7:0], exp)
	endtask
	initial
	begin
		#400000;
		mismatches++;
		stop_test();
	end
	// ****
	// Tests
	// ****
	initial
	begin
		arst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mismatches = 0;
		total_checks = 0;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		reg_read(`REG_STATUS, rdv);
		`CHK(rdv, 16'h0002)
		reg_read(4'hc, rdv);
		`CHK(rdv, 16'h0000)
		load(`ACT_CMD, `BS_LOW, `CMD_WR_FLASH);
		`CHK(active_cmd, `CMD_WR_FLASH)
		for (int i = 0; i < 2; i++)
		begin
			load(`ACT_ADDR, `BS_LOW, 8'h85 + 8'(i));
			load(`ACT_DATA, `BS_LOW, 8'h34 + 8'(i));
			load(`ACT_DATA, `BS_HIGH, 8'h12 + 8'(i));
			step(`KIND_LATCH, `ACT_IDLE, `BS_HIGH, 8'h00);
		end
		load(`ACT_ADDR, `BS_HIGH, 8'h00);
		load(`ACT_ADDR, `BS_EXT, 8'h00);
		b0 = busy_cycles;
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		`CHK(busy_cycles - b0, WR_CYC)
		load(`ACT_CMD, `BS_LOW, `CMD_NOP);
		b0 = busy_cycles;
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		`CHK(busy_cycles - b0, 0)
		load(`ACT_CMD, `BS_LOW, `CMD_RD_FLASH);
		for (int i = 0; i < 2; i++)
		begin
			load(`ACT_ADDR, `BS_LOW, 8'h85 + 8'(i));
			rd_chk(`BS_LOW, 8'h34 + 8'(i));
			rd_chk(`BS_HIGH, 8'h12 + 8'(i));
		end
		load(`ACT_CMD, `BS_LOW, `CMD_WR_EE);
		load(`ACT_ADDR, `BS_HIGH, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			load(`ACT_ADDR, `BS_LOW, 8'h23 + 8'(i));
			load(`ACT_DATA, `BS_LOW, 8'ha5 + 8'(i));
			step(`KIND_LATCH, `ACT_IDLE, `BS_LOW, 8'h00);
		end
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		load(`ACT_CMD, `BS_LOW, `CMD_RD_EE);
		for (int i = 0; i < 2; i++)
		begin
			load(`ACT_ADDR, `BS_LOW, 8'h23 + 8'(i));
			rd_chk(`BS_LOW, 8'ha5 + 8'(i));
		end
		load(`ACT_CMD, `BS_LOW, `CMD_WR_FUSE);
		for (int i = 0; i < 3; i++)
		begin
			load(`ACT_DATA, `BS_LOW, FUSE[i]);
			step(`KIND_WRITE, `ACT_IDLE, WPAIR[i], 8'h00);
		end
		load(`ACT_CMD, `BS_LOW, `CMD_RD_FUSE);
		for (int i = 0; i < 3; i++)
			rd_chk(RPAIR[i], FUSE[i]);
		load(`ACT_CMD, `BS_LOW, `CMD_WR_LOCK);
		load(`ACT_DATA, `BS_LOW, 8'hfc);
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		load(`ACT_DATA, `BS_LOW, 8'hc3);
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		load(`ACT_DATA, `BS_LOW, 8'hff);
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		load(`ACT_CMD, `BS_LOW, `CMD_RD_FUSE);
		rd_chk(`BS_HIGH, 8'hfc);
		load(`ACT_CMD, `BS_LOW, `CMD_ERASE);
		step(`KIND_WRITE, `ACT_IDLE, `BS_LOW, 8'h00);
		load(`ACT_CMD, `BS_LOW, `CMD_RD_FUSE);
		rd_chk(`BS_HIGH, 8'hff);
		load(`ACT_CMD, `BS_LOW, `CMD_RD_SIG);
		for (int i = 0; i < 3; i++)
		begin
			load(`ACT_ADDR, `BS_LOW, 8'(i));
			rd_chk(`BS_LOW, SIG[i]);
		end
		rd_chk(`BS_HIGH, 8'h6e);
		load(`ACT_IDLE, `BS_LOW, 8'h55);
		`CHK(active_cmd, `CMD_RD_SIG)
		stop_test();
	end
endmodule
